// ---- verilog/asp_pkg.sv ----
/*
 * asp_pkg: constants shared by the serial host port of the converter:
 * command opcodes, register addresses, field masks and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package asp_pkg;

	localparam int        FRAME_BITS = 24;        // register command frame
	localparam int        TX_BITS    = 24;        // outgoing word length
	localparam int        CONV_BITS  = 16;        // conversion result width

	// command frame fields
	localparam int        OPC_MSB    = 23;
	localparam int        OPC_LSB    = 19;
	localparam int        ADR_MSB    = 18;
	localparam int        ADR_LSB    = 8;
	localparam int        DAT_MSB    = 7;

	typedef enum logic [4:0] {
		ASP_NO_OPERATION_CMD = 5'h00,
		ASP_WRITE_CMD        = 5'h01,
		ASP_READ_CMD         = 5'h02,
		ASP_SET_MASK_CMD     = 5'h03,
		ASP_CLEAR_MASK_CMD   = 5'h04
	} asp_opcode_e;

	// register addresses
	localparam logic [10:0] ADDR_UNLOCK     = 11'h000;
	localparam logic [10:0] ADDR_POWER      = 11'h004;
	localparam logic [10:0] ADDR_IN_PROTO   = 11'h008;
	localparam logic [10:0] ADDR_OUT_PROTO  = 11'h00c;
	localparam logic [10:0] ADDR_CFG_LAST   = 11'h011;

	// unlock key, writable bits of the other registers, reset values
	localparam logic [7:0]  UNLOCK_KEY      = 8'haa;
	localparam logic [7:0]  POWER_MASK      = 8'h1e;
	localparam logic [7:0]  IN_PROTO_MASK   = 8'h03;
	localparam logic [7:0]  OUT_PROTO_MASK  = 8'h07;
	localparam logic [7:0]  REG_RESET       = 8'h00;

	// field positions in the output protocol register
	localparam int        RD_PROTO_LSB    = 0;
	localparam int        LANE_WIDTH_BIT  = 2;

endpackage : asp_pkg

// ---- verilog/asp_port.sv ----
/*
 * asp_port: device end of the converter's serial host port. Takes
 * 24-bit command frames on the serial input, keeps the interface
 * configuration registers, and shifts register or conversion data out
 * on one or two lanes, with an optional companion clock on ready.
 * Unmapped addresses read back as zero and drop writes.
 * Assumes: sclk_i stops while cs_n_i is high; cs_n_i stays high for at
 * least four clk_i periods between frames, and the first serial edge
 * comes at least three clk_i periods after cs_n_i falls.
 */
module asp_port
	import asp_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 sclk_i,
	input  wire logic                 cs_n_i,
	input  wire logic                 sdi_i,
	input  wire logic [CONV_BITS-1:0] conv_data_i,
	output logic                      first_data_out_o,
	output logic                      first_data_out_oe_o,
	output logic                      second_data_out_o,
	output logic                      second_data_out_oe_o,
	output logic                      ready_o,
	output logic [1:0]                write_protocol_select_o,
	output logic [1:0]                read_protocol_select_o,
	output logic                      output_lane_width_o,
	output logic                      write_unlocked_o,
	output logic [7:0]                power_control_o
);

	// register file and command state, system clock domain
	logic [7:0]          unlock_reg, unlock_next;
	logic [7:0]          power_reg, power_next;
	logic [7:0]          in_proto_reg, in_proto_next;
	logic [7:0]          out_proto_reg, out_proto_next;
	logic                rd_pend_reg, rd_pend_next;
	logic [7:0]          rd_data_reg, rd_data_next;
	logic [TX_BITS-1:0]  tx_word_reg, tx_word_next;
	logic                cs_meta_reg, cs_sync_reg, cs_prev_reg;
	logic                cap_fall_reg, cap_fall_next;
	logic                cpha_reg, cpha_next;
	logic                unlocked_reg, unlocked_next;

	// capture side, serial clock domain
	logic [FRAME_BITS-1:0] rx_shift_reg, rx_shift_next;
	logic [4:0]            rx_cnt_reg, rx_cnt_next;
	logic                  armed_reg;

	// launch side, serial clock domain
	logic [4:0]            tx_cnt_reg, tx_cnt_next;
	logic                  ready_reg, ready_next;

	logic                  cap_clk, launch_clk, link_rst;
	logic                  cs_rise, retimer, dual;

	// reads one bit of the outgoing word, zero past its end
	function automatic logic word_bit(input logic [TX_BITS-1:0] w,
	                                  input logic [6:0] pos);
		if (pos < 7'(TX_BITS))
			return w[TX_BITS-1-int'(pos)];
		return 1'b0;
	endfunction : word_bit

	// interface configuration range, guarded by the unlock key
	function automatic logic is_cfg(input logic [10:0] adr);
		return (adr != ADDR_UNLOCK) && (adr <= ADDR_CFG_LAST);
	endfunction : is_cfg

	// capture edge is the falling edge when polarity and phase differ;
	// mode only changes while cs is high, so the switch is glitch-safe
	// cs high holds the link logic in reset, so a clock re-parked
	// between frames cannot count as a bit
	assign cap_clk    = sclk_i ^ cap_fall_reg;
	assign launch_clk = ~cap_clk;
	assign link_rst   = rst_i | cs_n_i;
	assign cs_rise    = cs_sync_reg & ~cs_prev_reg;
	assign retimer    = out_proto_reg[RD_PROTO_LSB +: 2] != 2'b00;
	assign dual       = out_proto_reg[LANE_WIDTH_BIT];

	// chip select synchroniser into the system domain
	// the first flop feeds no logic; the third keeps the last level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end else begin
			cs_meta_reg <= cs_n_i;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
		end
	end

	// command execution at the synchronised cs rise; the received word
	// is stable here because the serial clock has stopped
	// a read latches the register here so later writes leave it alone
	always_comb begin
		logic [4:0]  opc;
		logic [10:0] adr;
		logic [7:0]  dat;
		logic [7:0]  cur;
		logic [7:0]  val;
		logic        ok;
		opc            = rx_shift_reg[OPC_MSB:OPC_LSB];
		adr            = rx_shift_reg[ADR_MSB:ADR_LSB];
		dat            = rx_shift_reg[DAT_MSB:0];
		cur            = REG_RESET;
		val            = REG_RESET;
		ok             = 1'b0;
		unlock_next    = unlock_reg;
		power_next     = power_reg;
		in_proto_next  = in_proto_reg;
		out_proto_next = out_proto_reg;
		rd_pend_next   = rd_pend_reg;
		rd_data_next   = rd_data_reg;
		unique case (adr)
			ADDR_UNLOCK:    cur = unlock_reg;
			ADDR_POWER:     cur = power_reg;
			ADDR_IN_PROTO:  cur = in_proto_reg;
			ADDR_OUT_PROTO: cur = out_proto_reg;
			default:        cur = REG_RESET;
		endcase
		val = cur;
		// short frames are conversion reads and carry no command
		if (cs_rise && rx_cnt_reg == 5'(FRAME_BITS)) begin
			rd_pend_next = 1'b0;
			unique case (opc)
				ASP_WRITE_CMD: begin
					val = dat;
					ok  = 1'b1;
				end
				ASP_SET_MASK_CMD: begin
					val = cur | dat;
					ok  = 1'b1;
				end
				ASP_CLEAR_MASK_CMD: begin
					val = cur & ~dat;
					ok  = 1'b1;
				end
				ASP_READ_CMD: begin
					rd_pend_next = 1'b1;
					rd_data_next = cur;
				end
				default: ok = 1'b0;
			endcase
			if (is_cfg(adr) && unlock_reg != UNLOCK_KEY)
				ok = 1'b0;
			if (ok) begin
				unique case (adr)
					ADDR_UNLOCK:    unlock_next    = val;
					ADDR_POWER:     power_next     = val & POWER_MASK;
					ADDR_IN_PROTO:  in_proto_next  = val & IN_PROTO_MASK;
					ADDR_OUT_PROTO: out_proto_next = val & OUT_PROTO_MASK;
					default:        unlock_next    = unlock_reg;
				endcase
			end
		end else if (cs_rise) begin
			rd_pend_next = 1'b0;
		end
		// registered so the unlock status pin comes from a flop
		unlocked_next = unlock_next == UNLOCK_KEY;
	end

	// outgoing word and clock edge choice, refreshed only while cs high
	// the word freezes once the synchronised cs is low, which is before
	// the first serial edge may come, so no bit moves inside a frame
	always_comb begin
		tx_word_next  = tx_word_reg;
		cap_fall_next = cap_fall_reg;
		cpha_next     = cpha_reg;
		if (cs_sync_reg && !cs_rise) begin
			cap_fall_next = in_proto_reg[1] ^ in_proto_reg[0];
			cpha_next     = in_proto_reg[0];
			if (rd_pend_reg)
				tx_word_next = {rd_data_reg, {(TX_BITS-8){1'b0}}};
			else
				tx_word_next = {conv_data_i, {(TX_BITS-CONV_BITS){1'b0}}};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			unlock_reg    <= REG_RESET;
			power_reg     <= REG_RESET;
			in_proto_reg  <= REG_RESET;
			out_proto_reg <= REG_RESET;
			rd_pend_reg   <= 1'b0;
			rd_data_reg   <= REG_RESET;
			tx_word_reg   <= '0;
			cap_fall_reg  <= 1'b0;
			cpha_reg      <= 1'b0;
			unlocked_reg  <= 1'b0;
		end else begin
			unlock_reg    <= unlock_next;
			power_reg     <= power_next;
			in_proto_reg  <= in_proto_next;
			out_proto_reg <= out_proto_next;
			rd_pend_reg   <= rd_pend_next;
			rd_data_reg   <= rd_data_next;
			tx_word_reg   <= tx_word_next;
			cap_fall_reg  <= cap_fall_next;
			cpha_reg      <= cpha_next;
			unlocked_reg  <= unlocked_next;
		end
	end

	// serial input shift; the count restarts on the first edge of a frame
	// instead of at cs rise, so it survives for the system side to read
	always_comb begin
		rx_shift_next = {rx_shift_reg[FRAME_BITS-2:0], sdi_i};
		if (!armed_reg)
			rx_cnt_next = 5'd1;
		else if (rx_cnt_reg != 5'h1f)
			rx_cnt_next = rx_cnt_reg + 5'd1;
		else
			rx_cnt_next = rx_cnt_reg;
	end

	always_ff @(posedge cap_clk or posedge rst_i) begin
		if (rst_i) begin
			rx_shift_reg <= '0;
			rx_cnt_reg   <= 5'h00;
		end else begin
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg   <= rx_cnt_next;
		end
	end

	// cleared while cs is high so the next frame counts from one
	// cs is the link's own framing signal, so it acts here unsynchronised
	always_ff @(posedge cap_clk or posedge link_rst) begin
		if (link_rst)
			armed_reg <= 1'b0;
		else
			armed_reg <= 1'b1;
	end

	// launch edge counter and companion clock on ready
	// ready flips on every launch edge while the read protocol is non-zero (else held low), so either host edge can capture
	always_comb begin
		tx_cnt_next = (tx_cnt_reg != 5'h1f) ? tx_cnt_reg + 5'd1 : tx_cnt_reg;
		ready_next  = retimer ? ~ready_reg : 1'b0;
	end

	always_ff @(posedge launch_clk or posedge link_rst) begin
		if (link_rst) begin
			tx_cnt_reg <= 5'h00;
			ready_reg  <= 1'b0;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			ready_reg  <= ready_next;
		end
	end

	// lane data: the bit slot advances on each launch edge; with phase
	// set the first launch edge presents the first bit. a small mux on
	// flops keeps the first bit valid right at cs fall
	// limitation: lanes settle through the mux just after each launch edge
	always_comb begin
		logic [6:0] slot;
		slot = 7'(tx_cnt_reg);
		if (cpha_reg && tx_cnt_reg != 5'h00)
			slot = slot - 7'd1;
		if (dual) begin
			second_data_out_o = word_bit(tx_word_reg, 7'(slot << 1));
			first_data_out_o  = word_bit(tx_word_reg,
			                             7'((slot << 1) + 7'd1));
		end else begin
			second_data_out_o = 1'b0;
			first_data_out_o  = word_bit(tx_word_reg, slot);
		end
	end

	// lanes released whenever cs is high; second lane only in dual mode
	// enables follow the pin directly so release at cs rise is immediate
	assign first_data_out_oe_o     = ~cs_n_i;
	assign second_data_out_oe_o    = ~cs_n_i & dual;
	assign ready_o                 = ready_reg;
	assign write_protocol_select_o = in_proto_reg[1:0];
	assign read_protocol_select_o  = out_proto_reg[RD_PROTO_LSB +: 2];
	assign output_lane_width_o     = out_proto_reg[LANE_WIDTH_BIT];
	assign write_unlocked_o        = unlocked_reg;
	assign power_control_o         = power_reg;

endmodule : asp_port

// ---- verif/asp_port_props.sv ----
/* asp_port_props: pin and configuration checks on the serial port.
   Assumes it is bound onto asp_port and sees only its ports. */
module asp_port_props (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cs_n_i,
	input wire logic       first_data_out_oe_o,
	input wire logic       second_data_out_o,
	input wire logic       second_data_out_oe_o,
	input wire logic       ready_o,
	input wire logic [1:0] write_protocol_select_o,
	input wire logic [1:0] read_protocol_select_o,
	input wire logic       output_lane_width_o,
	input wire logic       write_unlocked_o,
	input wire logic [7:0] power_control_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// lane enables follow select, lane 1 only when two lanes
	AST_OE0_CS: assert property (first_data_out_oe_o == !cs_n_i)
		else $error("lane 0 enable not tied to select");
	AST_OE1_WIDTH: assert property (second_data_out_oe_o ==
		(!cs_n_i && output_lane_width_o))
		else $error("lane 1 enable wrong");
	AST_SDO1_QUIET: assert property (!output_lane_width_o |->
		!second_data_out_o)
		else $error("lane 1 data while single lane");
	AST_READY_LOW: assert property (!cs_n_i &&
		read_protocol_select_o == 2'h0 |-> !ready_o)
		else $error("ready high in plain protocol");
	// commands only land after the frame closes
	AST_CFG_HOLD: assert property (!cs_n_i && !$past(cs_n_i) |->
		$stable(power_control_o) && $stable(write_protocol_select_o))
		else $error("config changed inside a frame");
	AST_AFTER_CS: assert property ($changed(write_protocol_select_o) |->
		$past(cs_n_i, 2))
		else $error("protocol changed too soon after select rise");
	AST_LOCK: assert property ($changed(power_control_o) |->
		write_unlocked_o)
		else $error("locked register changed");
	AST_READY_IDLE: assert property (cs_n_i && $past(cs_n_i, 4) |->
		$stable(ready_o))
		else $error("ready moved between frames");
	COV_DUAL: cover property (!cs_n_i && output_lane_width_o);
	COV_RETIME: cover property ($rose(ready_o));
	COV_UNLOCK: cover property ($rose(write_unlocked_o));
endmodule : asp_port_props

bind asp_port asp_port_props asp_port_props_i (.clk_i, .rst_i, .cs_n_i,
	.first_data_out_oe_o, .second_data_out_o, .second_data_out_oe_o,
	.ready_o, .write_protocol_select_o, .read_protocol_select_o,
	.output_lane_width_o, .write_unlocked_o, .power_control_o);

// ---- verif/asp_host.sv ----
/* asp_host: host controller model driving select, serial clock and
   command input. Assumes the port samples on the selected edge. */
module asp_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo0_i,
	input  wire logic sdo1_i,
	input  wire logic ready_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: deselected, clock parked low
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end
	// one 24-clock frame; clock only runs while selected
	task automatic xfer(input logic [1:0] m, input logic [23:0] cmd,
		input logic dual, output logic [23:0] rx, output int rdy);
		logic r0;
		rx = '0;
		rdy = 0;
		sclk_o = m[1];
		#20; // park the clock at its idle level before select falls
		cs_n_o = 1'b0;
		#100; // first edge four system clocks after select
		r0 = ready_i;
		for (int i = 0; i < 24; i++) begin
			if (m[0]) sclk_o = ~sclk_o;
			sdi_o = cmd[23-i];
			#7.5;
			if (ready_i !== r0) rdy++;
			r0 = ready_i;
			if (!dual) rx[23-i] = sdo0_i;
			else if (i < 12) {rx[23-2*i], rx[22-2*i]} = {sdo1_i, sdo0_i};
			sclk_o = ~sclk_o; // capture edge
			#7.5;
			if (!m[0]) sclk_o = ~sclk_o;
		end
		#10;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // released line never keeps its last level
		#160;
	endtask : xfer
endmodule : asp_host

// ---- verif/asp_port_tb_top.sv ----
/* asp_port_tb_top: self-checking bench for the serial host port.
   Assumes asp_pkg, asp_port and the host model are compiled first. */
module asp_port_tb_top import asp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_i, sclk, cs_n, sdi, sdo0, oe0, sdo1, oe1, rdy, lw, unl;
	logic [1:0]  wps, rps, md;
	logic [7:0]  pwr;
	logic [23:0] rx;
	logic [CONV_BITS-1:0] conv;
	int miscompares, comparisons, rdy_cnt;
	logic h0, h1;
	// host sees the inverse of a released lane, so a late enable shows
	assign h0 = oe0 ? sdo0 : ~sdo0;
	assign h1 = oe1 ? sdo1 : ~sdo1;

	asp_port asp_port_i (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .sdi_i(sdi), .conv_data_i(conv),
		.first_data_out_o(sdo0), .first_data_out_oe_o(oe0),
		.second_data_out_o(sdo1), .second_data_out_oe_o(oe1),
		.ready_o(rdy), .write_protocol_select_o(wps),
		.read_protocol_select_o(rps), .output_lane_width_o(lw),
		.write_unlocked_o(unl), .power_control_o(pwr));
	asp_host asp_host_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
		.sdo0_i(h0), .sdo1_i(h1), .ready_i(rdy));

	// 40 MHz system clock
	always #12.5 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	// frame in the current protocol; d picks two-lane capture
	task automatic fr(input logic [23:0] c, input logic d);
		asp_host_i.xfer(md, c, d, rx, rdy_cnt);
	endtask : fr
	task automatic wr(input logic [10:0] a, input logic [7:0] v);
		fr({ASP_WRITE_CMD, a, v}, lw);
	endtask : wr

	task automatic t_reset();
		chk("reset", 24'h0, {7'h0, wps, rps, lw, unl, oe0, oe1, rdy, pwr});
		fr(24'h0, 1'b0);
		chk("conv", {conv, 8'h00}, rx);
	endtask : t_reset
	task automatic t_regs();
		wr(ADDR_POWER, 8'hff);
		chk("locked", 24'h0, {16'h0, pwr});
		wr(ADDR_UNLOCK, UNLOCK_KEY);
		chk("unlock", 24'h1, {23'h0, unl});
		wr(ADDR_POWER, 8'hff);
		chk("write", 24'h1e, {16'h0, pwr});
		fr({ASP_CLEAR_MASK_CMD, ADDR_POWER, 8'h06}, 1'b0);
		chk("clear", 24'h18, {16'h0, pwr});
		fr({ASP_SET_MASK_CMD, ADDR_POWER, 8'h02}, 1'b0);
		chk("set", 24'h1a, {16'h0, pwr});
		fr({5'h07, ADDR_POWER, 8'h00}, 1'b0);
		chk("reserved", 24'h1a, {16'h0, pwr});
		fr({ASP_READ_CMD, ADDR_POWER, 8'h00}, 1'b0);
		fr(24'h0, 1'b0);
		chk("readback", 24'h1a0000, rx);
	endtask : t_regs
	// protocols 1 to 3 each set in the old one, then used
	task automatic t_modes();
		for (int m = 1; m < 4; m++) begin
			wr(ADDR_IN_PROTO, 8'(m));
			md = 2'(m);
			chk("protocol", 24'(m), {22'h0, wps});
			fr(24'h0, 1'b0);
			chk("conv mode", {conv, 8'h00}, rx);
		end
	endtask : t_modes
	task automatic t_lanes();
		wr(ADDR_OUT_PROTO, 8'h04);
		chk("width sel", 24'h4, {21'h0, lw, rps});
		fr(24'h0, 1'b1);
		chk("dual", {conv, 8'h00}, rx);
		chk("ready plain", 24'd0, 24'(rdy_cnt));
		wr(ADDR_OUT_PROTO, 8'h05);
		chk("retimer sel", 24'h5, {21'h0, lw, rps});
		fr(24'h0, 1'b1);
		chk("retimer", {conv, 8'h00}, rx);
		chk("ready edges", 24'd24, 24'(rdy_cnt));
	endtask : t_lanes
	// reset in mid-run brings back the default protocol and registers
	task automatic t_rerst();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		md = 2'h0;
		chk("rerst", 24'h0, {7'h0, wps, rps, lw, unl, oe0, oe1, rdy, pwr});
		fr(24'h0, 1'b0);
		chk("conv rerst", {conv, 8'h00}, rx);
	endtask : t_rerst

	// bounded run: a hang counts as a mismatch
	initial begin
		repeat (50000) @(posedge clk_i);
		miscompares++;
		final_report();
	end
	// reset, then the scenarios in order
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		conv = 16'ha5c3;
		md = 2'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_regs();
		t_modes();
		t_lanes();
		t_rerst();
		final_report();
	end
endmodule : asp_port_tb_top
